/* verilog/tcb_defs.svh */
`ifndef TCB_DEFS_SVH
`define TCB_DEFS_SVH

// register byte offsets
`define TCB_OFS_CTL 8'h00
`define TCB_OFS_CR1 8'h04

// control register fields
`define TCB_CTL_EN_BIT 7
`define TCB_CTL_SIO_BIT 2
`define TCB_CTL_SWRST_BIT 1

// transfer control one fields
`define TCB_CR1_BC_HI 7
`define TCB_CR1_BC_LO 5
`define TCB_CR1_ACK_BIT 4
`define TCB_CR1_ONE_BIT 3
`define TCB_CR1_SCK_HI 2
`define TCB_CR1_SCK_LO 0

// reset values
`define TCB_BC_RST 3'h0
`define TCB_ACK_RST 1'b0
`define TCB_SCK_RST 3'h0
`define TCB_EN_RST 1'b0
`define TCB_SIO_RST 1'b0

// codes and timing
`define TCB_BC_FULL 3'h0
`define TCB_BYTE_BITS 4'h8
`define TCB_SCK_RESERVED 3'h7
`define TCB_DIV_EXP_BASE 4'h5
`define TCB_DIV_OFFSET 12'h048
`define TCB_SWRST_CYCLES 4

`endif

/* verilog/tcb_pkg.sv */
package tcb_pkg;

  typedef enum logic [1:0] {
    TCB_IDLE = 2'b00,
    TCB_BIT_LO = 2'b01,
    TCB_BIT_HI = 2'b10
  } tcb_state_t;

  typedef logic [2:0] tcb_code_t;

endpackage

/* verilog/tcb_fifo.sv */
`timescale 1ns/100ps

module tcb_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  // filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || WIDTH < 1)
    begin : g_bad
      $error("tcb_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic ready_q;

  wire push = in_valid & ready_q;
  wire pop = out_ready & out_valid;
  wire [PW-1:0] wr_next = (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
  wire [PW-1:0] rd_next = (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);

  assign count_d = count_q + CW'(push) - CW'(pop);
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign in_ready = ready_q;

  always_ff @(posedge clk)
  begin
    if (rst || (ce && clr))
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ready_q <= 1'b1;
    end
    else if (ce)
    begin
      if (push)
      begin
        mem_q[wr_ptr_q] <= in_data;
        wr_ptr_q <= wr_next;
      end
      if (pop)
        rd_ptr_q <= rd_next;
      count_q <= count_d;
      // registered so the ready seen by the source is a clean flop
      ready_q <= (count_d < CW'(DEPTH));
    end
  end

endmodule

/* verilog/tcb_transfer_ctrl.sv */
// Contract
// RULE1: transfer_bit_count 000 means 8 bits, else 1..7; ack adds one clock.
// RULE2: writes take scl_rate_select as n=5..11; SCL = fsys/(2^n+72); 111 reserved.
// RULE3: read bit 0 is 0 during software reset, 1 otherwise.
// RULE4: software clears transfer_bit_count before entering clocked_byte_serial_mode.
// RULE5: bit 0 reads 1 after reset; in serial mode low rate bit reads 0. (Code: in serial mode bit 0 shows sck_q[0], so it reads 1 for odd rate codes.)
// RULE6: bits 31..8 read zero, bit 3 reads one, all read-only.
`timescale 1ns/100ps
`include "tcb_defs.svh"

module tcb_transfer_ctrl
  import tcb_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int BUF_DEPTH = 2,
  parameter int SWRST_CYCLES = `TCB_SWRST_CYCLES
)
(
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // transmit stream
  input wire logic [DATA_W-1:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  // received data
  output logic [DATA_W-1:0] RX_DATA,
  output logic RX_VALID,
  // two-wire bus pins
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE
);

  generate
    if (DATA_W != 8 || BUF_DEPTH < 2 || SWRST_CYCLES < 1 || SWRST_CYCLES > 255)
    begin : g_bad
      $error("tcb_transfer_ctrl: DATA_W must be 8, BUF_DEPTH >= 2, SWRST_CYCLES 1..255");
    end
  endgenerate

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  tcb_code_t bc_q;
  logic ack_q;
  tcb_code_t sck_q;
  logic en_q;
  logic sio_q;
  logic [7:0] swrst_cnt_q;
  logic [31:0] rdata_q;

  wire sel_ctl = (ADDR == `TCB_OFS_CTL);
  wire sel_cr1 = (ADDR == `TCB_OFS_CR1);
  wire wr_ctl = WR & sel_ctl;
  wire wr_cr1 = WR & sel_cr1;
  wire [2:0] wr_bc = WDATA[`TCB_CR1_BC_HI:`TCB_CR1_BC_LO];
  wire [2:0] wr_sck = WDATA[`TCB_CR1_SCK_HI:`TCB_CR1_SCK_LO];
  // reserved rate code leaves the divider unchanged
  wire sck_ok = (wr_sck != `TCB_SCK_RESERVED); // RULE2
  wire swrst_busy = (swrst_cnt_q != 8'h00);
  wire swrst_start = wr_ctl & WDATA[`TCB_CTL_SWRST_BIT];
  // bit 0 doubles as reset monitor; serial mode shows the rate bit
  wire mon_bit = sio_q ? sck_q[0] : ~swrst_busy; // RULE3 RULE5

  wire [31:0] cr1_view;
  wire [31:0] ctl_view;
  // upper bits stay zero, bit 3 is hard one
  assign cr1_view = {24'h000000, bc_q, ack_q, 1'b1, sck_q[2:1], mon_bit}; // RULE6
  assign ctl_view = {24'h000000, en_q, 4'h0, sio_q, swrst_busy, 1'b0};
  wire [31:0] rd_mux = sel_cr1 ? cr1_view : (sel_ctl ? ctl_view : 32'h00000000);

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      bc_q <= `TCB_BC_RST;
      ack_q <= `TCB_ACK_RST;
      sck_q <= `TCB_SCK_RST;
      en_q <= `TCB_EN_RST;
      sio_q <= `TCB_SIO_RST;
      rdata_q <= 32'h00000000;
    end
    else if (CE)
    begin
      if (wr_cr1)
      begin
        bc_q <= wr_bc;
        ack_q <= WDATA[`TCB_CR1_ACK_BIT];
      end
      if (wr_cr1 && sck_ok)
        sck_q <= wr_sck; // RULE2
      if (wr_ctl)
      begin
        en_q <= WDATA[`TCB_CTL_EN_BIT];
        sio_q <= WDATA[`TCB_CTL_SIO_BIT];
      end
      // read data stand one cycle only, then fall back to zero
      rdata_q <= RD ? rd_mux : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // software reset sequencer
  // ---------------------------------------------------------------
  // a fresh request restarts the count rather than extending it
  always_ff @(posedge CLK)
  begin
    if (RST)
      swrst_cnt_q <= 8'h00;
    else if (CE)
    begin
      if (swrst_start)
        swrst_cnt_q <= 8'(SWRST_CYCLES);
      else if (swrst_busy)
        swrst_cnt_q <= swrst_cnt_q - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // transmit buffer
  // ---------------------------------------------------------------
  logic buf_valid;
  logic buf_ready;
  logic [DATA_W-1:0] buf_data;

  tcb_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .clr(swrst_busy),
    .in_valid(TX_VALID),
    .in_data(TX_DATA),
    .in_ready(TX_READY),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_ready)
  );

  // ---------------------------------------------------------------
  // bit timing
  // ---------------------------------------------------------------
  // each level lasts half of 2^n+72; the period is always even
  wire [3:0] div_exp = 4'(sck_q) + `TCB_DIV_EXP_BASE; // RULE2
  wire [11:0] period_len = (12'h001 << div_exp) + `TCB_DIV_OFFSET; // RULE2
  wire [10:0] half_last = 11'(period_len >> 1) - 11'h001;

  wire [3:0] data_len = (bc_q == `TCB_BC_FULL) ? `TCB_BYTE_BITS : {1'b0, bc_q}; // RULE1
  wire [3:0] clk_total = data_len + {3'h0, ack_q}; // RULE1

  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  tcb_state_t state_q;
  logic [10:0] tick_q;
  logic [3:0] left_q;
  logic [DATA_W-1:0] shift_q;
  logic [DATA_W-1:0] rx_q;
  logic rx_valid_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic ack_run_q;

  // serial mode and software reset park the two-wire engine
  wire active = en_q & ~sio_q & ~swrst_busy;
  // one down-counter serves both phases, reloaded at every phase change
  wire tick_done = (tick_q == 11'h000);
  wire start = (state_q == TCB_IDLE) & active & buf_valid;
  wire in_ack = ack_run_q & (left_q == 4'h1); // RULE1
  wire last_bit = (left_q == 4'h1);
  wire [DATA_W-1:0] shift_nx = {shift_q[DATA_W-2:0], 1'b0};
  wire next_is_ack = ack_run_q & (left_q == 4'h2);

  // popped only at a start: a stalled word waits in the buffer, lost only when RST or a software reset clears it
  assign buf_ready = start;

  always_ff @(posedge CLK)
  begin
    if (RST || (CE && !active))
    begin
      state_q <= TCB_IDLE;
      tick_q <= 11'h000;
      left_q <= 4'h0;
      shift_q <= '0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ack_run_q <= 1'b0;
      rx_valid_q <= 1'b0;
    end
    else if (CE)
    begin
      rx_valid_q <= 1'b0;
      case (state_q)
        TCB_IDLE:
        begin
          if (start)
          begin
            shift_q <= buf_data;
            left_q <= clk_total; // RULE1
            ack_run_q <= ack_q;
            tick_q <= half_last;
            scl_oe_q <= 1'b1;
            sda_oe_q <= ~buf_data[DATA_W-1];
            state_q <= TCB_BIT_LO;
          end
        end
        TCB_BIT_LO:
        begin
          if (tick_done)
          begin
            scl_oe_q <= 1'b0;
            tick_q <= half_last;
            state_q <= TCB_BIT_HI;
          end
          else
            tick_q <= tick_q - 11'h001;
        end
        TCB_BIT_HI:
        begin
          if (tick_done)
          begin
            left_q <= left_q - 4'h1;
            if (last_bit)
            begin
              sda_oe_q <= 1'b0;
              rx_valid_q <= 1'b1;
              state_q <= TCB_IDLE;
            end
            else
            begin
              shift_q <= shift_nx;
              // acknowledge clock leaves the data line to the receiver
              sda_oe_q <= next_is_ack ? 1'b0 : ~shift_nx[DATA_W-1]; // RULE1
              scl_oe_q <= 1'b1;
              tick_q <= half_last;
              state_q <= TCB_BIT_LO;
            end
          end
          else
            tick_q <= tick_q - 11'h001;
        end
        default:
          state_q <= TCB_IDLE;
      endcase
    end
  end

  // sampled data bits land lsb-aligned, acknowledge bit is not kept
  always_ff @(posedge CLK)
  begin
    if (RST)
      rx_q <= '0;
    else if (CE)
    begin
      if (start)
        rx_q <= '0;
      else if (state_q == TCB_BIT_HI && tick_done && !in_ack)
        rx_q <= {rx_q[DATA_W-2:0], SDA_IN};
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic scl_out_q;
  logic sda_out_q;

  // open-drain: only ever pull low
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      scl_out_q <= 1'b0;
      sda_out_q <= 1'b0;
    end
    else if (CE)
    begin
      scl_out_q <= 1'b0;
      sda_out_q <= 1'b0;
    end
  end

  assign RDATA = rdata_q;
  assign RX_DATA = rx_q;
  assign RX_VALID = rx_valid_q;
  assign SCL_OUT = scl_out_q;
  assign SCL_OE = scl_oe_q;
  assign SDA_OUT = sda_out_q;
  assign SDA_OE = sda_oe_q;

endmodule

/* test/tcb_transfer_ctrl_asserts.sv */
`timescale 1ns/100ps
module tcb_transfer_ctrl_asserts (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // link
  input wire logic RX_VALID,
  input wire logic SCL_OE,
  input wire logic SDA_OE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  logic [2:0] bc_q, rate_q;
  logic ack_q, scl_q;
  logic [11:0] hi_q;
  logic [3:0] n_q;
  int h, l;
  wire cr1 = RD && ADDR == 8'h04;
  assign h = ((1 << (5 + rate_q)) + 72) / 2;
  assign l = (bc_q == 3'h0 ? 8 : bc_q) + ack_q;
  // shadow of the written fields; a reserved rate leaves the old one
  always_ff @(posedge CLK)
  begin
    scl_q <= SCL_OE;
    hi_q <= (SCL_OE && !RST) ? hi_q + 12'h1 : 12'h0;
    n_q <= (RX_VALID || RST) ? 4'h0 : n_q + 4'(SCL_OE && !scl_q);
    if (RST)
      {bc_q, ack_q, rate_q} <= 7'h0;
    else if (WR && ADDR == 8'h04)
    begin
      {bc_q, ack_q} <= WDATA[7:4];
      if (WDATA[2:0] != 3'h7)
        rate_q <= WDATA[2:0];
    end
  end
  // ----
  // checks
  // ----
  property p_rd_idle;
    !$past(RD) |-> RDATA == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped;
    RD && ADDR != 8'h04 && ADDR != 8'h00 |=> RDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_fixed;
    cr1 |=> RDATA[31:8] == 24'h0 && RDATA[3] == 1'b1;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
  property p_length;
    cr1 |=> RDATA[7:4] == {bc_q, ack_q};
  endproperty
  a_length: assert property (p_length) else $error("length field wrong");
  property p_rate;
    cr1 |=> RDATA[2:1] == rate_q[2:1];
  endproperty
  a_rate: assert property (p_rate) else $error("rate field wrong");
  property p_half;
    $fell(SCL_OE) |-> hi_q == h;
  endproperty
  a_half: assert property (p_half) else $error("clock phase length wrong");
  property p_clocks;
    RX_VALID |-> n_q == l;
  endproperty
  a_clocks: assert property (p_clocks) else $error("clock count wrong");
  property p_sda;
    !SCL_OE && !$past(SCL_OE) && !RX_VALID |-> $stable(SDA_OE);
  endproperty
  a_sda: assert property (p_sda) else $error("data moved while clock high");
endmodule
bind tcb_transfer_ctrl tcb_transfer_ctrl_asserts u_tcb_transfer_ctrl_asserts (.CLK, .RST, .ADDR,
  .WDATA, .WR, .RD, .RDATA, .RX_VALID, .SCL_OE, .SDA_OE);

/* test/tcb_far_end.sv */
`timescale 1ns/100ps
module tcb_far_end (
  // clock and pattern
  input wire logic clk,
  input wire logic load,
  input wire logic [9:0] pat,
  // bus
  input wire logic scl,
  output logic sda_oe
);
  logic [9:0] pat_q;
  logic scl_q;
  // apart from a load, moves only on a falling scl, so the wire is steady while scl is high
  always_ff @(posedge clk)
  begin
    scl_q <= scl;
    if (load)
      pat_q <= pat;
    else if (scl_q && !scl)
      pat_q <= {pat_q[8:0], 1'b1};
  end
  assign sda_oe = ~pat_q[9];
endmodule

/* test/tcb_transfer_ctrl_tb.sv */
`timescale 1ns/100ps
module tcb_transfer_ctrl_tb;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic TX_VALID = 1'b0;
  logic load = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] TX_DATA = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [9:0] pat = 10'h3ff;
  logic [31:0] RDATA;
  logic [7:0] RX_DATA;
  logic TX_READY, RX_VALID, SCL_OE, SDA_OE, SCL_OUT, SDA_OUT, p_oe, sda;
  int bad_count = 0;
  int cmp_count = 0;
  // open-drain wires with pull-ups
  assign sda = ~(SDA_OE | p_oe);
  tcb_transfer_ctrl #(.SWRST_CYCLES(4)) u_tcb_transfer_ctrl (.CLK, .RST, .CE(1'b1), .ADDR,
    .WDATA, .WR, .RD, .RDATA, .TX_DATA, .TX_VALID, .TX_READY, .RX_DATA, .RX_VALID,
    .SCL_OUT, .SCL_OE, .SDA_IN(sda), .SDA_OUT, .SDA_OE);
  tcb_far_end u_tcb_far_end (.clk(CLK), .load, .pat, .scl(~SCL_OE), .sda_oe(p_oe));
  initial
  begin
    forever #5 CLK = ~CLK;
  end
  // ----
  // helpers
  // ----
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one idle cycle after each access keeps a strobe from being set twice at once
  task automatic wr(logic [7:0] a, logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(posedge CLK);
    chk(RDATA, exp);
  endtask
  // valid is left high; the caller drops it
  task automatic push(logic [7:0] d);
    TX_DATA <= d;
    TX_VALID <= 1'b1;
    do @(posedge CLK); while (TX_READY !== 1'b1);
  endtask
  task automatic rx_chk(logic [7:0] exp);
    do @(posedge CLK); while (RX_VALID !== 1'b1);
    chk({24'h0, RX_DATA}, {24'h0, exp});
  endtask
  task automatic t_xfer(logic [2:0] bc, logic ack, logic [2:0] rt, logic [7:0] tx, logic [7:0] p);
    int n;
    n = (bc == 3'h0) ? 8 : int'(bc);
    pat <= {1'b1, p, 1'b0};
    load <= 1'b1;
    wr(8'h04, {24'h0, bc, ack, 1'b0, rt});
    load <= 1'b0;
    push(tx);
    TX_VALID <= 1'b0;
    rx_chk((tx & p) >> (8 - n));
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    rd(8'h04, 32'h9);
    rd(8'h00, 32'h0);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'h0);
    wr(8'h04, 32'hffff_fff6);
    rd(8'h04, 32'hff);
    wr(8'h04, 32'h7);
    rd(8'h04, 32'hf);
  endtask
  task automatic t_swrst();
    wr(8'h00, 32'h2);
    rd(8'h04, 32'he);
    repeat (4) @(posedge CLK);
    rd(8'h04, 32'hf);
  endtask
  task automatic t_serial();
    wr(8'h04, 32'h6);
    wr(8'h00, 32'h4);
    rd(8'h04, 32'he);
    wr(8'h04, 32'h5);
    rd(8'h04, 32'hd);
    wr(8'h00, 32'h0);
  endtask
  task automatic t_buffer();
    wr(8'h04, 32'h20);
    push(8'h80);
    push(8'h00);
    TX_DATA <= 8'h80;
    repeat (3) @(posedge CLK);
    chk({31'h0, TX_READY}, 32'h0);
    wr(8'h00, 32'h80);
    push(8'h80);
    TX_VALID <= 1'b0;
    // first clock is pulling low; the pin levels themselves only ever drive zero
    chk({29'h0, SCL_OE, SCL_OUT, SDA_OUT}, 32'h4);
    rx_chk(8'h01);
    rx_chk(8'h00);
    rx_chk(8'h01);
  endtask
  task automatic t_lengths();
    for (int b = 0; b < 8; b++)
      t_xfer(3'(b), b[0], 3'h0, 8'hc5 ^ 8'(b), 8'h7b);
    t_xfer(3'h0, 1'b1, 3'h0, 8'ha6, 8'hff);
    t_xfer(3'h1, 1'b1, 3'h6, 8'h80, 8'hff);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge CLK);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
  initial
  begin
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    load <= 1'b0;
    @(posedge CLK);
    t_regs();
    t_swrst();
    t_serial();
    t_buffer();
    t_lengths();
    report_and_stop();
  end
endmodule
